/* File: src/page_select_bank.sv */
/*
 * Page select register with four save slots and a priority level tracker,
 * reached over an APB slave port.
 * Assumes one 125 MHz clock, an APB master on the same clock, and request
 * and return strobes from the core that are synchronous to it.
 */
// Contract
// - There are exactly four independent slots, each holding one saved page.
// - Execution runs at one of six levels: main, levels 0 to 3, then NMI as the top.
// - A serviced level is preempted only by a strictly higher request.
// - NMI always ranks above level 3 and its rank cannot be programmed.
// - A write with only the page field set makes that page active, no slot touched.
// - The slot field at bits 5:4 picks the slot for save and restore.
// - Operation 10 saves the active page in the slot and activates the written page.
// - Operation 11 ignores the written page and restores it from the slot.
// - Operation and slot fields zero select the page without saving.
// - Reading the page field returns the active page.
// - Bit 3 is reserved and reads as zero.
`timescale 1ns/1ns
`include "page_defs.svh"
module page_select_bank
   import page_pkg::*;
(
   input  wire logic                    sys_clk_i,
   input  wire logic                    nrst_i,
   input  wire logic                    psel_i,
   input  wire logic                    penable_i,
   input  wire logic                    pwrite_i,
   input  wire logic [`PG_ADDR_W-1:0]   paddr_i,
   input  wire logic [31:0]             pwdata_i,
   output      logic [31:0]             prdata_o,
   output      logic                    pready_o,
   output      logic                    pslverr_o,
   input  wire logic [`PG_NUM_REQ-1:0]  int_req_i,
   input  wire logic                    nmi_req_i,
   input  wire logic                    int_ret_i,
   output      logic [2:0]              active_page_o,
   output      logic [2:0]              cur_level_o,
   output      logic                    grant_o,
   output      logic [2:0]              grant_level_o
);

   // ****************************************************************
   // Declarations
   // ****************************************************************

   logic [31:0]            prdata_ff;
   logic [31:0]            nxt_prdata;
   logic                   pready_ff;
   logic                   nxt_pready;
   logic                   pslverr_ff;
   logic                   nxt_pslverr;
   page_t                  page_ff;
   page_t                  nxt_page;
   logic [`PG_NUM_REQ-1:0] lvlen_ff;
   logic [`PG_NUM_REQ-1:0] nxt_lvlen;
   logic [5:1]             insvc_ff;
   logic [5:1]             nxt_insvc;
   level_e                 cur_level_ff;
   level_e                 nxt_cur_level;
   logic                   grant_ff;
   logic                   nxt_grant;
   level_e                 grant_level_ff;
   level_e                 nxt_grant_level;
   logic                   setup;
   logic                   mapped;
   logic                   wr_fire;
   logic [1:0]             wr_op;
   page_t                  wr_page;

   slot_if sl ();

   page_slot_store u_slots
   (
      .sys_clk_i (sys_clk_i),
      .nrst_i    (nrst_i),
      .sl        (sl)
   );

   // ****************************************************************
   // APB slave
   // ****************************************************************

   // Decode and write qualification; a write lands only at the edge that
   // completes the access phase, so a stalled master never writes twice.
   assign setup   = psel_i && !penable_i;
   assign mapped  = (paddr_i == `PG_ADDR_PAGE) || (paddr_i == `PG_ADDR_STATUS) ||
                    (paddr_i == `PG_ADDR_LVLEN);
   assign wr_fire = psel_i && penable_i && pready_ff && pwrite_i && !pslverr_ff;
   assign wr_op   = pwdata_i[`PG_OP_MSB:`PG_OP_LSB];
   assign wr_page = pwdata_i[`PG_PAGE_MSB:`PG_PAGE_LSB];

   // Read data is captured in the setup cycle so every output is a flop;
   // the cost is that the access phase always completes in its first cycle.
   always_comb
   begin
      nxt_pready  = 1'b0;
      nxt_pslverr = 1'b0;
      nxt_prdata  = prdata_ff;
      if (setup)
      begin
         nxt_pready  = 1'b1;
         nxt_pslverr = !mapped;
         nxt_prdata  = 32'h0;
         if (!pwrite_i)
         begin
            case (paddr_i)
               `PG_ADDR_PAGE:
               begin
                  nxt_prdata[`PG_PAGE_MSB:`PG_PAGE_LSB] = page_ff;
               end
               `PG_ADDR_STATUS:
               begin
                  nxt_prdata[`PG_PAGE_MSB:`PG_PAGE_LSB] = page_ff;
                  nxt_prdata[`PG_ST_LVL_MSB:`PG_ST_LVL_LSB] = cur_level_ff;
               end
               `PG_ADDR_LVLEN:
               begin
                  nxt_prdata[`PG_NUM_REQ-1:0] = lvlen_ff;
               end
               default:
               begin
                  nxt_prdata = 32'h0;
               end
            endcase
         end
      end
   end

   // Bus answer registers.
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         prdata_ff  <= 32'h0;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end
      else
      begin
         prdata_ff  <= nxt_prdata;
         pready_ff  <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   // ****************************************************************
   // Page register and slot control
   // ****************************************************************

   // Operation 01 is not defined and leaves the page and the slots alone.
   always_comb
   begin
      nxt_page    = page_ff;
      nxt_lvlen   = lvlen_ff;
      sl.save_stb = 1'b0;
      sl.sel      = pwdata_i[`PG_SLOT_MSB:`PG_SLOT_LSB];
      sl.save_val = page_ff;
      if (wr_fire && (paddr_i == `PG_ADDR_LVLEN))
      begin
         nxt_lvlen = pwdata_i[`PG_NUM_REQ-1:0];
      end
      if (wr_fire && (paddr_i == `PG_ADDR_PAGE))
      begin
         case (wr_op)
            `PG_OP_DIRECT:
            begin
               nxt_page = wr_page;
            end
            `PG_OP_SAVE:
            begin
               nxt_page    = wr_page;
               sl.save_stb = 1'b1;
            end
            `PG_OP_RESTORE:
            begin
               nxt_page = sl.rd_val;
            end
            default:
            begin
               nxt_page = page_ff;
            end
         endcase
      end
   end

   // Page and level enable registers; page 0 is active after reset.
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         page_ff  <= `PG_PAGE_RST;
         lvlen_ff <= `PG_LVLEN_RST;
      end
      else
      begin
         page_ff  <= nxt_page;
         lvlen_ff <= nxt_lvlen;
      end
   end

   // ****************************************************************
   // Priority level tracker
   // ****************************************************************

   // Each in-service bit stands for one nested level; main is implied.
   // A return and a new grant never share a cycle, so the nesting
   // cannot skip a level while unwinding.
   always_comb
   begin
      logic [5:1] req;
      int         top;
      int         hp;
      req             = {nmi_req_i, int_req_i & lvlen_ff};
      top             = 0;
      hp              = 0;
      nxt_insvc       = insvc_ff;
      nxt_grant       = 1'b0;
      nxt_grant_level = grant_level_ff;
      for (int i = 1; i <= 5; i++)
      begin
         if (req[i])
         begin
            hp = i;
         end
      end
      if (int_ret_i && (cur_level_ff != LVL_MAIN))
      begin
         nxt_insvc[cur_level_ff] = 1'b0;
      end
      else if (hp > int'(cur_level_ff))
      begin
         nxt_insvc[hp]   = 1'b1;
         nxt_grant       = 1'b1;
         nxt_grant_level = level_e'(hp[2:0]);
      end
      for (int i = 1; i <= 5; i++)
      begin
         if (nxt_insvc[i])
         begin
            top = i;
         end
      end
      nxt_cur_level = level_e'(top[2:0]);
   end

   // Tracker registers.
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         insvc_ff       <= 5'h0;
         cur_level_ff   <= LVL_MAIN;
         grant_ff       <= 1'b0;
         grant_level_ff <= LVL_MAIN;
      end
      else
      begin
         insvc_ff       <= nxt_insvc;
         cur_level_ff   <= nxt_cur_level;
         grant_ff       <= nxt_grant;
         grant_level_ff <= nxt_grant_level;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************

   assign prdata_o      = prdata_ff;
   assign pready_o      = pready_ff;
   assign pslverr_o     = pslverr_ff;
   assign active_page_o = page_ff;
   assign cur_level_o   = cur_level_ff;
   assign grant_o       = grant_ff;
   assign grant_level_o = grant_level_ff;

   // ****************************************************************
   // Assertions
   // ****************************************************************

   sequence s_page_wr (logic [1:0] op);
      wr_fire && (paddr_i == `PG_ADDR_PAGE) && (wr_op == op);
   endsequence

   sequence s_page_rd;
      setup && !pwrite_i && (paddr_i == `PG_ADDR_PAGE);
   endsequence

   a_direct_page_set : assert property (
      @(posedge sys_clk_i) disable iff (!nrst_i)
      s_page_wr(`PG_OP_DIRECT) |=> (page_ff == $past(wr_page)) && !$past(sl.save_stb))
      else $error("direct write did not set page or touched a slot");

   a_save_then_load : assert property (
      @(posedge sys_clk_i) disable iff (!nrst_i)
      s_page_wr(`PG_OP_SAVE) |-> sl.save_stb && (sl.save_val == page_ff)
                                 ##1 page_ff == $past(wr_page))
      else $error("save write did not save old page and load new one");

   a_restore_page : assert property (
      @(posedge sys_clk_i) disable iff (!nrst_i)
      s_page_wr(`PG_OP_RESTORE) |=> page_ff == $past(sl.rd_val))
      else $error("restore did not load page from slot");

   a_page_readback : assert property (
      @(posedge sys_clk_i) disable iff (!nrst_i)
      s_page_rd |=> pready_o && (prdata_o[`PG_PAGE_MSB:`PG_PAGE_LSB] == $past(page_ff)))
      else $error("page read does not show active page");

   a_reserved_zero : assert property (
      @(posedge sys_clk_i) disable iff (!nrst_i)
      s_page_rd |=> prdata_o[31:`PG_PAGE_MSB+1] == 29'h0)
      else $error("reserved page bits read nonzero");

   a_preempt_higher : assert property (
      @(posedge sys_clk_i) disable iff (!nrst_i)
      grant_o |-> (grant_level_o > $past(cur_level_ff)) && (cur_level_o == grant_level_o))
      else $error("grant to a level not above the running one");

   a_nmi_top_rank : assert property (
      @(posedge sys_clk_i) disable iff (!nrst_i)
      nmi_req_i && !int_ret_i && (cur_level_ff != LVL_NMI)
      |=> grant_o && (grant_level_o == LVL_NMI))
      else $error("NMI request not granted at top level");

   a_return_unwinds : assert property (
      @(posedge sys_clk_i) disable iff (!nrst_i)
      int_ret_i && (cur_level_ff != LVL_MAIN)
      |=> (cur_level_ff < $past(cur_level_ff)) && !grant_o)
      else $error("return did not drop to a lower level");

endmodule // page_select_bank

/* File: src/page_defs.svh */
/*
 * Constants of the page select register bank: bus offsets, field positions,
 * operation codes and reset values.
 * Assumes it is included by bare name from every design file that needs it.
 */
`ifndef PAGE_DEFS_SVH
`define PAGE_DEFS_SVH

// Byte offsets on the register bus.
`define PG_ADDR_W        12
`define PG_ADDR_PAGE     12'h000
`define PG_ADDR_STATUS   12'h004
`define PG_ADDR_LVLEN    12'h008

// Fields of the page register.
`define PG_PAGE_LSB      0
`define PG_PAGE_MSB      2
`define PG_SLOT_LSB      4
`define PG_SLOT_MSB      5
`define PG_OP_LSB        6
`define PG_OP_MSB        7

// Operation codes.
`define PG_OP_DIRECT     2'h0
`define PG_OP_SAVE       2'h2
`define PG_OP_RESTORE    2'h3

// Status register field holding the running priority level.
`define PG_ST_LVL_LSB    4
`define PG_ST_LVL_MSB    6

// Sizes and reset values.
`define PG_NUM_SLOTS     4
`define PG_NUM_REQ       4
`define PG_PAGE_RST      3'h0
`define PG_LVLEN_RST     4'h0

`endif

/* File: src/page_pkg.sv */
/*
 * Types shared by the page select register bank.
 * Assumes the constants header is compiled alongside.
 */
package page_pkg;

   typedef logic [2:0] page_t;
   typedef logic [1:0] slot_t;

   // Priority levels in ascending order; the last one is the highest.
   typedef enum logic [2:0]
   {
      LVL_MAIN,
      LVL_INT0,
      LVL_INT1,
      LVL_INT2,
      LVL_INT3,
      LVL_NMI
   } level_e;

endpackage

/* File: src/slot_if.sv */
/*
 * Carrier between the page register logic and its storage slots.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface slot_if;
   import page_pkg::*;

   logic    save_stb;
   slot_t   sel;
   page_t   save_val;
   page_t   rd_val;

   modport ctrl (output save_stb, output sel, output save_val, input rd_val);
   modport store (input save_stb, input sel, input save_val, output rd_val);
endinterface

/* File: src/page_slot_store.sv */
/*
 * Four storage slots for saved page values.
 * Assumes the controller raises save_stb for exactly one cycle per save.
 */
`timescale 1ns/1ns
`include "page_defs.svh"
module page_slot_store
   import page_pkg::*;
(
   input  wire logic   sys_clk_i,
   input  wire logic   nrst_i,
   slot_if.store       sl
);

   page_t slots_ff    [`PG_NUM_SLOTS];
   page_t nxt_slots   [`PG_NUM_SLOTS];

   // ****************************************************************
   // Slot storage
   // ****************************************************************

   // Only the selected slot changes on a save, the others stay intact.
   always_comb
   begin
      for (int i = 0; i < `PG_NUM_SLOTS; i++)
      begin
         nxt_slots[i] = slots_ff[i];
      end
      if (sl.save_stb)
      begin
         nxt_slots[sl.sel] = sl.save_val;
      end
   end

   // All slots clear on reset.
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         for (int i = 0; i < `PG_NUM_SLOTS; i++)
         begin
            slots_ff[i] <= `PG_PAGE_RST;
         end
      end
      else
      begin
         slots_ff <= nxt_slots;
      end
   end

   // Restore reads the selected slot combinationally.
   assign sl.rd_val = slots_ff[sl.sel];

   // A save lands in the chosen slot and leaves it readable.
   a_save_slot_hold : assert property (
      @(posedge sys_clk_i) disable iff (!nrst_i)
      sl.save_stb |=> slots_ff[$past(sl.sel)] == $past(sl.save_val))
      else $error("saved page not held in selected slot");

endmodule // page_slot_store

/* File: test/core_model.sv */
/*
 * Model of the core at the far side: interrupt requests, NMI, return pulses.
 * Assumes the bench calls its tasks from one process, on the bank's clock.
 */
`timescale 1ns/1ns
module core_model
(
   input  wire logic       sys_clk_i,
   output      logic [3:0] int_req_o,
   output      logic       nmi_req_o,
   output      logic       int_ret_o
);
   // ****************************************
   // Request and return drivers
   // ****************************************

   // Nothing is requested at time zero.
   initial
   begin
      int_req_o = 4'h0;
      nmi_req_o = 1'b0;
      int_ret_o = 1'b0;
   end

   // Requests are levels; software holds them until it clears the source.
   task automatic set(input logic [3:0] r, input logic n);
      @(posedge sys_clk_i);
      int_req_o <= r;
      nmi_req_o <= n;
   endtask

   // A return lasts one cycle, so a second call always lets an edge pass.
   task automatic ret();
      @(posedge sys_clk_i);
      int_ret_o <= 1'b1;
      @(posedge sys_clk_i);
      int_ret_o <= 1'b0;
   endtask
endmodule // core_model

/* File: test/testbench.sv */
/*
 * Self-checking bench of the page select bank: APB master, core model.
 * Assumes the bank answers each access within a few cycles.
 */
`timescale 1ns/1ns
`include "page_defs.svh"
module testbench
   import page_pkg::*;
;
   // ****************************************
   // Signals and notes
   // ****************************************
   typedef struct {logic wr; logic [31:0] d; logic err;} note_s;
   logic        sys_clk;
   logic        nrst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata_o;
   logic        pready_o;
   logic        pslverr_o;
   logic [3:0]  int_req;
   logic        nmi_req;
   logic        int_ret;
   logic [2:0]  active_page_o;
   logic [2:0]  cur_level_o;
   logic        grant_o;
   logic [2:0]  grant_level_o;
   note_s       notes[$];
   note_s       nt;
   logic [2:0]  grants[$];
   logic [2:0]  slot_val[4];
   logic [2:0]  cur;
   logic [31:0] rnd;
   int          errors;
   int          tests_run;
   int          cycles;

   page_select_bank dut (.sys_clk_i(sys_clk), .nrst_i(nrst), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .int_req_i(int_req), .nmi_req_i(nmi_req), .int_ret_i(int_ret),
      .active_page_o(active_page_o), .cur_level_o(cur_level_o),
      .grant_o(grant_o), .grant_level_o(grant_level_o));
   core_model core (.sys_clk_i(sys_clk), .int_req_o(int_req), .nmi_req_o(nmi_req),
      .int_ret_o(int_ret));

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // One APB transfer; the expected answer is noted for the monitor.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] e, input logic er);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      notes.push_back('{w, e, er});
      @(posedge sys_clk);
      penable <= 1'b1;
      // Ready is sampled at the rising edge, the same edge that completes the access.
      @(posedge sys_clk);
      while (pready_o !== 1'b1)
         @(posedge sys_clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Page register write data: operation, slot, reserved zero, page.
   function automatic logic [31:0] pg(input logic [1:0] op, input logic [1:0] s,
                                      input logic [2:0] p);
      return {24'h0, op, s, 1'b0, p};
   endfunction

   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   // ****************************************
   // Clock, timeout and monitor
   // ****************************************
   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // A hang is cut short well past the roughly 170 cycles the run needs.
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         results();
      end
   end

   // Every completed transfer and every grant is matched to its oldest note.
   always @(posedge sys_clk)
   begin
      if (psel && penable && pready_o === 1'b1)
      begin
         nt = notes.pop_front();
         check(32'(pslverr_o), 32'(nt.err));
         if (!nt.wr)
            check(prdata_o, nt.d);
      end
      if (grant_o === 1'b1)
      begin
         if (grants.size() == 0)
            check(32'(grant_level_o), 32'hff);
         else
            check(32'(grant_level_o), 32'(grants.pop_front()));
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      errors = 0;
      tests_run = 0;
      cycles = 0;
      rnd = 32'haf50;
      repeat (20) @(posedge sys_clk);
      nrst <= 1'b1;
      apb(0, `PG_ADDR_PAGE, 0, 32'h0, 0);
      apb(0, `PG_ADDR_STATUS, 0, 32'h0, 0);
      // Bit 3 written high must still read back as zero.
      apb(1, `PG_ADDR_PAGE, 32'h0d, 0, 0);
      apb(0, `PG_ADDR_PAGE, 0, 32'h05, 0);
      cur = 3'h5;
      // Each level saves into its own slot, as software is meant to.
      for (int s = 0; s < 4; s++)
      begin
         rnd = lfsr(rnd);
         slot_val[s] = cur;
         cur = rnd[2:0];
         apb(1, `PG_ADDR_PAGE, pg(2'h2, 2'(s), cur), 0, 0);
         apb(0, `PG_ADDR_PAGE, 0, 32'(cur), 0);
      end
      // A plain write selects a page and leaves the slots alone.
      cur = ~cur;
      apb(1, `PG_ADDR_PAGE, pg(2'h0, 2'h0, cur), 0, 0);
      settle(0);
      check(32'(active_page_o), 32'(cur));
      apb(1, `PG_ADDR_PAGE, pg(2'h1, 2'h2, ~cur), 0, 0);
      apb(0, `PG_ADDR_PAGE, 0, 32'(cur), 0);
      for (int s = 3; s >= 0; s--)
      begin
         rnd = lfsr(rnd);
         apb(1, `PG_ADDR_PAGE, pg(2'h3, 2'(s), rnd[2:0]), 0, 0);
         apb(0, `PG_ADDR_PAGE, 0, 32'(slot_val[s]), 0);
      end
      cur = slot_val[0];
      // A shared routine keeps the old page on the stack and writes it back directly.
      apb(1, `PG_ADDR_PAGE, pg(2'h0, 2'h0, ~cur), 0, 0);
      apb(1, `PG_ADDR_PAGE, pg(2'h0, 2'h0, cur), 0, 0);
      apb(0, `PG_ADDR_PAGE, 0, 32'(cur), 0);
      apb(1, `PG_ADDR_STATUS, 32'hff, 0, 0);
      apb(0, 12'h00c, 0, 32'h0, 1);
      apb(1, 12'h00c, 32'h0, 0, 1);
      // A masked request is not granted.
      core.set(4'h8, 1'b0);
      settle(3);
      check(32'(cur_level_o), 32'h0);
      core.set(4'h0, 1'b0);
      apb(1, `PG_ADDR_LVLEN, 32'hf, 0, 0);
      apb(0, `PG_ADDR_LVLEN, 0, 32'hf, 0);
      grants.push_back(3'h2);
      core.set(4'h2, 1'b0);
      settle(2);
      // Equal and lower requests wait; higher ones preempt.
      core.set(4'h3, 1'b0);
      settle(3);
      check(32'(cur_level_o), 32'h2);
      grants.push_back(3'h4);
      core.set(4'h9, 1'b0);
      settle(3);
      grants.push_back(3'h5);
      core.set(4'h9, 1'b1);
      settle(3);
      check(32'(cur_level_o), 32'h5);
      apb(0, `PG_ADDR_STATUS, 0, 32'h50 | 32'(cur), 0);
      core.set(4'h1, 1'b0);
      core.ret();
      settle(1);
      check(32'(cur_level_o), 32'h4);
      core.ret();
      settle(1);
      check(32'(cur_level_o), 32'h2);
      grants.push_back(3'h1);
      core.ret();
      settle(3);
      check(32'(cur_level_o), 32'h1);
      core.set(4'h0, 1'b0);
      core.ret();
      settle(2);
      check(32'(cur_level_o), 32'h0);
      // A second reset in mid-run clears page and slots again.
      apb(1, `PG_ADDR_PAGE, pg(2'h2, 2'h1, 3'h6), 0, 0);
      @(posedge sys_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      apb(0, `PG_ADDR_PAGE, 0, 32'h0, 0);
      apb(1, `PG_ADDR_PAGE, pg(2'h3, 2'h1, 3'h7), 0, 0);
      apb(0, `PG_ADDR_PAGE, 0, 32'h0, 0);
      settle(2);
      check(32'(notes.size() + grants.size()), 32'h0);
      results();
   end
endmodule // testbench
